// *** hw/gp_counter.v ***
// general purpose 16-bit up/down timer counter
`timescale 1ns/10ps
`include "gp_counter_defs.vh"
module gp_counter #(
    parameter WIDTH = `CNT_WIDTH
) (
    input wire ref_clk_i,              // system clock, 20 MHz
    input wire rst_i,                  // async reset, active high
    input wire int_tick_i,             // internal timebase level, same domain
    input wire ext_clk_i,              // external count clock pin
    input wire ext_gate_i,             // external gate pin, low stops
    input wire ext_dir_i,              // external direction pin, high up
    input wire clk_sel_i,              // 0 internal, 1 external clock
    input wire gate_sel_i,             // 0 internal, 1 external gate
    input wire dir_sel_i,              // 0 software, 1 pin direction
    input wire sw_dir_i,               // software direction, 1 up
    input wire sw_enable_i,            // software count enable
    input wire mode_i,                 // 0 terminal count, 1 rate generator
    input wire load_i,                 // one-cycle pulse: load initial count
    input wire [WIDTH-1:0] load_value_i, // initial count
    output reg [WIDTH-1:0] count_o,    // present count
    output reg out_o                   // counter output
);
    // sequencer states: nothing loaded yet, or a count loaded and live
    localparam ST_IDLE = 1'b0;  // ticks are refused until the first load
    localparam ST_ARMED = 1'b1; // ticks are counted while the gate allows

    // positions of the pins inside the synchroniser vector
    localparam PIN_CLK = 0;
    localparam PIN_GATE = 1;
    localparam PIN_DIR = 2;
    localparam NUM_PINS = 3;

    // constants matched to the counter width, so no sum is padded or cut
    localparam [WIDTH-1:0] VAL_ZERO = {WIDTH{1'b0}};
    localparam [WIDTH-1:0] VAL_ONE = {{(WIDTH-1){1'b0}}, 1'b1};

    // raw pin levels, gathered so one loop can synchronise them all
    wire [NUM_PINS-1:0] pin_raw;
    // pin levels after two flip-flops, safe for logic to read
    wire [NUM_PINS-1:0] pin_sync;

    // history of the count clock sources for edge detection
    reg clk_last;
    reg int_last;

    // sequencer state and its next value
    reg state;
    reg next_state;

    // reload value kept for the rate generator
    reg [WIDTH-1:0] initial_count;

    // next values of the registered outputs and the reload value
    reg [WIDTH-1:0] next_count;
    reg [WIDTH-1:0] next_initial;
    reg next_out;

    // decoded control terms
    wire ext_edge;
    wire int_edge;
    wire tick;
    wire gate_open;
    wire count_up;
    wire step_en;
    wire [WIDTH-1:0] stepped;

    // gather the asynchronous pins; the order follows the PIN_ indices
    assign pin_raw = {ext_dir_i, ext_gate_i, ext_clk_i};

    // two-stage synchroniser per pin; only the second stage is read outside
    genvar g;
    generate
        for (g = 0; g < NUM_PINS; g = g + 1) begin : pin_sync_gen
            reg meta;
            reg sync;
            always @(posedge ref_clk_i or posedge rst_i) begin
                if (rst_i) begin
                    meta <= 1'b0;
                    sync <= 1'b0;
                end else begin
                    meta <= pin_raw[g];
                    sync <= meta;
                end
            end
            assign pin_sync[g] = sync;
        end
    endgenerate

    // one more stage on each clock source to find its rising edge
    // both history bits clear to the idle low level, so a pin that is
    // already high at release gives one edge, which is refused while idle
    always @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            clk_last <= 1'b0;
            int_last <= 1'b0;
        end else begin
            clk_last <= pin_sync[PIN_CLK];
            int_last <= int_tick_i;
        end
    end

    // rising edge of the external pin, two reference cycles late
    assign ext_edge = pin_sync[PIN_CLK] & ~clk_last;
    // rising edge of the internal timebase, same domain, no synchroniser
    assign int_edge = int_tick_i & ~int_last;
    // selected count clock
    assign tick = (clk_sel_i == `SEL_EXTERNAL) ? ext_edge : int_edge;

    // gate: software always, pin only when the external gate is selected
    assign gate_open = sw_enable_i & ((gate_sel_i == `SEL_INTERNAL) | pin_sync[PIN_GATE]);

    // direction: high or one counts up, low or zero counts down
    assign count_up = (dir_sel_i == `SEL_EXTERNAL) ? pin_sync[PIN_DIR] : sw_dir_i;

    // one step per selected clock edge while armed and gated open
    assign step_en = (state == ST_ARMED) & tick & gate_open;

    // the value one step on, wrapping at the ends of the range
    assign stepped = count_up ? count_o + VAL_ONE : count_o - VAL_ONE;

    // next state, count, reload value and output
    // a load wins over a tick in the same cycle, so software always
    // sees its own value first; ticks before the first load do nothing
    always @* begin
        next_state = state;
        next_count = count_o;
        next_initial = initial_count;
        next_out = out_o;
        case (state)
            ST_IDLE: begin
                if (load_i) begin
                    next_state = ST_ARMED;
                    next_count = load_value_i;
                    next_initial = load_value_i;
                    next_out = 1'b0;
                end
            end
            ST_ARMED: begin
                if (load_i) begin
                    // a new count restarts either mode with the output low
                    next_count = load_value_i;
                    next_initial = load_value_i;
                    next_out = 1'b0;
                end else if (step_en) begin
                    if (mode_i == `MODE_TERMINAL_COUNT) begin
                        if (count_o != VAL_ZERO) begin
                            // output rises on the step that reaches zero
                            next_count = stepped;
                            next_out = (stepped == VAL_ZERO);
                        end else begin
                            // zero holds, no wrap, output stays high
                            next_out = 1'b1;
                        end
                    end else begin
                        if (count_o == VAL_ONE) begin
                            // end of the period: reload and drop the output
                            next_count = initial_count;
                            next_out = 1'b0;
                        end else begin
                            // output is high for the one tick spent at one
                            next_count = stepped;
                            next_out = (stepped == VAL_ONE);
                        end
                    end
                end else if ((mode_i == `MODE_TERMINAL_COUNT) && (count_o == VAL_ZERO)) begin
                    // a loaded zero reports terminal count without a tick
                    next_out = 1'b1;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // registers; the count is a plain register, so reading it
    // never stalls or changes the counting
    always @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state <= ST_IDLE;
            count_o <= VAL_ZERO;
            initial_count <= VAL_ZERO;
            out_o <= 1'b0;
        end else begin
            state <= next_state;
            count_o <= next_count;
            initial_count <= next_initial;
            out_o <= next_out;
        end
    end

    // usage notes for whoever drives this block:
    // the external clock pin must stay well below half of the
    // reference rate, or edges merge inside the synchroniser;
    // the rate generator needs an initial count above one, which
    // the hardware does not police; counting up in rate mode
    // reaches one only after wrapping through the whole range;
    // the internal timebase arrives as a level on int_tick_i, since
    // the reference clock is slower than that timebase
endmodule

// *** pkg/gp_counter_defs.vh ***
// constants for the general purpose up/down counter
`ifndef GP_COUNTER_DEFS_VH
`define GP_COUNTER_DEFS_VH
`define CNT_WIDTH 16
`define CNT_ZERO 16'h0000
`define CNT_ONE 16'h0001
`define MODE_TERMINAL_COUNT 1'b0
`define MODE_RATE_GENERATOR 1'b1
`define SEL_INTERNAL 1'b0
`define SEL_EXTERNAL 1'b1
`define INT_TIMEBASE_HZ 24000000
`define EXT_CLK_MAX_HZ 20000000
`endif

// *** tb/gp_counter_sva.sv ***
// counter port checks
`timescale 1ns/10ps
module gp_counter_sva #(parameter WIDTH=16) (input wire ref_clk_i, rst_i, mode_i, load_i, sw_enable_i,
    input wire dir_sel_i, sw_dir_i, out_o, input wire [WIDTH-1:0] load_value_i, count_o);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    load_take_a: assert property (load_i |=> count_o==$past(load_value_i)) else $error("load");
    load_low_a: assert property (load_i && load_value_i>1 |=> !out_o) else $error("arm");
    gate_off_a: assert property (!load_i && !sw_enable_i |=> $stable(count_o)) else $error("gate");
    one_step_a: assert property (!load_i && !mode_i |=> WIDTH'(count_o+1'b1-$past(count_o))<3) else $error("step");
    tc_hold_a: assert property (!mode_i && out_o && !load_i |=> out_o) else $error("hold");
    tc_zero_a: assert property (!mode_i && $rose(out_o) |-> count_o==0) else $error("zero");
    rate_one_a: assert property (mode_i && $rose(out_o) |-> count_o==1) else $error("rate");
    down_dir_a: assert property (!load_i && !mode_i && !dir_sel_i && !sw_dir_i |=> count_o!=$past(count_o)+1'b1)
        else $error("dir");
    cover property (mode_i && out_o);
    cover property (!mode_i && out_o);
    cover property (!sw_enable_i);
endmodule

// *** tb/ext_pins_model.sv ***
// external count clock pin model
`timescale 1ns/10ps
module ext_pins_model (input wire ref_clk_i, run_i, output reg pin_clk_o = 0);
    reg [2:0] div = 0;
    // pin clock of eight ref cycles, still between bursts
    always @(posedge ref_clk_i) begin
        div <= run_i ? div + 3'h1 : 3'h0;
        pin_clk_o <= run_i & div[2];
    end
endmodule

// *** tb/testbench.sv ***
// counter bench
`timescale 1ns/10ps
module testbench;
    reg ref_clk_i=0, rst_i=1, int_tick_i=0, clk_sel_i=0, gate_sel_i=0, dir_sel_i=0, sw_dir_i=0, sw_enable_i=1;
    reg mode_i=0, load_i=0, run_i=0, ext_gate_i=1, ext_dir_i=0;
    reg [15:0] load_value_i=0, v;
    wire ext_clk_i, out_o;
    wire [15:0] count_o;
    integer fails=0, tests_run=0, i, n;
    gp_counter gp_counter_inst (.*);
    ext_pins_model ext_pins_model_inst (.ref_clk_i, .run_i, .pin_clk_o(ext_clk_i));
    initial forever #25 ref_clk_i=~ref_clk_i;
    function [15:0] ex(input integer k); ex=v+k; endfunction
    task c(input [15:0] g, e); tests_run++; if (g!==e) begin fails++; $display("Error %0t %h %h", $time, g, e); end endtask
    task w(input integer k); repeat (k) @(negedge ref_clk_i); endtask
    task t(input integer k); repeat (k) begin int_tick_i=1; w(2); int_tick_i=0; w(2); end endtask
    task ld(input m, input [15:0] s); mode_i=m; load_value_i=s; load_i=1; w(1); load_i=0; w(1); endtask
    task results; $display("fails %0d tests_run %0d", fails, tests_run);
        if (fails==0 && tests_run>0) $display("ALL TESTS PASSED"); else $display("TESTS FAILED"); $finish; endtask
    initial begin #90000 fails++; results; end
    // down count, terminal hold, gates, pin clock and direction, rate generator
    initial begin
        v=$urandom(99790); w(12); rst_i=0; v=2+$urandom%8; ld(0, v); c(out_o, 0);
        for (i=1; i<=v; i++) begin t(1); c(count_o, ex(-i)); end
        t(2); c(out_o, 1);
        sw_dir_i=1; v=$urandom%16'h7000+16; ld(0, v); t(3); c(count_o, ex(3));
        sw_enable_i=0; t(2); c(count_o, ex(3));
        gate_sel_i=1; sw_enable_i=1; ext_gate_i=0; w(4); t(2); c(count_o, ex(3));
        ext_gate_i=1; dir_sel_i=1; clk_sel_i=1; w(4); run_i=1; w(32); run_i=0; w(8); c(count_o, ex(-1));
        clk_sel_i=0; dir_sel_i=0; sw_dir_i=0; n=2+$urandom%5; ld(1, n[15:0]); c(out_o, 0);
        for (i=1; i<=2*n+1; i++) begin t(1); c(count_o, n-i%n); c(out_o, i%n==n-1); end
        results;
    end
endmodule
bind gp_counter gp_counter_sva #(.WIDTH(WIDTH)) gp_counter_sva_inst (.*);
